// ===== common/edhcpd_consts.vh
// constants for the edh control pin decoder
// Behaviour
// - three-bit field index output, bit 2 most significant.
// - reset low holds all control logic in reset.
// - receive/transmit select high selects receive mode.
// - receive/transmit select low selects transmit mode.
// - crc mode input high enables crc check, low disables.
// - ntsc blanking: 19 lines when select low, 9 lines when high.
// - pal composite blanking: 17 lines when low, 7 lines when high.
// - passthru high forwards error packets unchanged, no insert or update.
// - bit-reverse high mirrors the ten-bit video output bus.
// - blanking control low replaces video words by blanking levels.
// - tracker disable high stops flywheel, low keeps it running.
// - clip-and-fix high enables sync blanking, clipping and trs insertion.
// - pin and host bit merge into one effective control value.
// - and/or operators combine pin and host bit logically.
// - pin-precedence operator uses the pin, ignores host bit.
// - host-precedence operator uses host bit, ignores the pin.
// - everything is timed by the rising pixel clock edge.
// - tracker disable is pin or host bit.
`ifndef EDHCPD_CONSTS_VH
`define EDHCPD_CONSTS_VH
`define EDHCPD_OP_AND 2'h0
`define EDHCPD_OP_OR 2'h1
`define EDHCPD_OP_PIN 2'h2
`define EDHCPD_OP_HOST 2'h3
`define EDHCPD_VBI_NTSC_LONG 5'h13
`define EDHCPD_VBI_NTSC_SHORT 5'h09
`define EDHCPD_VBI_PAL_LONG 5'h11
`define EDHCPD_VBI_PAL_SHORT 5'h07
`define EDHCPD_FIELD_RST 3'h0
`define EDHCPD_SYNC_RST 9'h000
`define EDHCPD_SYNC_BLANK_RST 9'h008
`define EDHCPD_FLAG_RST 1'b0
`define EDHCPD_VIDEO_RST 10'h000
`define EDHCPD_BLANK_LUMA 10'h040
`define EDHCPD_BLANK_CHROMA 10'h200
`endif

// ===== design/edhcpd_decode.v
// static control pin decoder with pin/host merge
`timescale 1ns/10ps
`include "edhcpd_consts.vh"
module edhcpd_decode (
    input wire pixel_clock_in,
    input wire rst_n,
    input wire rx_tx_select,
    input wire crc_mode_pin,
    input wire vblank_length_select,
    input wire host_vblank_length_select,
    input wire error_packet_passthru,
    input wire lsb_top_pin,
    input wire blank_en_n,
    input wire timing_tracker_disable,
    input wire host_timing_tracker_disable,
    input wire clip_and_sync_fix_enable,
    input wire is_pal,
    input wire is_composite,
    input wire [2:0] field_in,
    input wire [9:0] video_in,
    output reg [2:0] field_index,
    output reg receive_mode,
    output reg transmit_mode,
    output reg crc_check_enable,
    output reg [4:0] vblank_lines,
    output reg packet_insert_enable,
    output reg tracker_enable,
    output reg sync_blank_enable,
    output reg clip_enable,
    output reg trs_insert_enable,
    output reg blanking_active,
    output reg [9:0] video_out
);
    // one generic merge so every pin/host pair uses the same operator table
    function merge;
        input [1:0] op;
        input pin_val;
        input host_val;
        begin
            case (op)
                `EDHCPD_OP_AND: merge = pin_val & host_val;
                `EDHCPD_OP_OR: merge = pin_val | host_val;
                `EDHCPD_OP_PIN: merge = pin_val;
                default: merge = host_val;
            endcase
        end
    endfunction

    // written out bit by bit so the wiring of the mirror is plain to see
    function [9:0] reverse10;
        input [9:0] d;
        begin
            reverse10[0] = d[9];
            reverse10[1] = d[8];
            reverse10[2] = d[7];
            reverse10[3] = d[6];
            reverse10[4] = d[5];
            reverse10[5] = d[4];
            reverse10[6] = d[3];
            reverse10[7] = d[2];
            reverse10[8] = d[1];
            reverse10[9] = d[0];
        end
    endfunction

    // short or long blanking interval by the merged select
    function [4:0] pick_lines;
        input sel;
        input [4:0] short_len;
        input [4:0] long_len;
        begin
            pick_lines = sel ? short_len : long_len;
        end
    endfunction

    // two-stage synchroniser, first stage read only by second
    reg [8:0] sync_a;
    reg [8:0] sync_b;
    // packing order fixes the sync_b bit of every pin below
    wire [8:0] raw_pins = {
        rx_tx_select,
        crc_mode_pin,
        vblank_length_select,
        error_packet_passthru,
        lsb_top_pin,
        blank_en_n,
        timing_tracker_disable,
        clip_and_sync_fix_enable,
        host_vblank_length_select
    };
    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= `EDHCPD_SYNC_BLANK_RST;
        end else begin
            sync_a <= raw_pins;
        end
    end

    // blanking stage resets high so video is not blanked out of reset
    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_b <= `EDHCPD_SYNC_BLANK_RST;
        end else begin
            sync_b <= sync_a;
        end
    end

    wire s_rx = sync_b[8];
    wire s_crc = sync_b[7];
    wire s_vbl = sync_b[6];
    wire s_pass = sync_b[5];
    wire s_lsb = sync_b[4];
    wire s_blank_n = sync_b[3];
    wire s_fly = sync_b[2];
    wire s_clip = sync_b[1];
    wire s_host_vbl = sync_b[0];
    // host tracker bit is assumed to come from host logic on this clock
    // combining operator of each control that also has a host bit
    localparam [1:0] FLY_OP = `EDHCPD_OP_OR;
    localparam [1:0] VBL_OP = `EDHCPD_OP_AND;
    wire eff_fly_dis = merge(FLY_OP, s_fly, host_timing_tracker_disable);
    // blanking length pin and host bit are and-merged
    wire eff_vbl = merge(VBL_OP, s_vbl, s_host_vbl);

    reg [4:0] next_vblank_lines;
    always @* begin
        if (!is_pal) begin
            next_vblank_lines = pick_lines(eff_vbl, `EDHCPD_VBI_NTSC_SHORT,
                `EDHCPD_VBI_NTSC_LONG);
        end else if (is_composite) begin
            next_vblank_lines = pick_lines(eff_vbl, `EDHCPD_VBI_PAL_SHORT,
                `EDHCPD_VBI_PAL_LONG);
        end else begin
            // pal component expects the select low; long interval either way
            next_vblank_lines = `EDHCPD_VBI_PAL_LONG;
        end
    end

    // blanking level by word parity: chroma-like words 0x200, luma words 0x040
    function [9:0] blank_level;
        input phase;
        begin
            if (phase) begin
                blank_level = `EDHCPD_BLANK_LUMA;
            end else begin
                blank_level = `EDHCPD_BLANK_CHROMA;
            end
        end
    endfunction

    reg word_phase;
    wire [9:0] blank_word = blank_level(word_phase);
    wire [9:0] staged = s_blank_n ? video_in : blank_word;

    // next values of the registered outputs
    // field index, bit 2 msb
    wire [2:0] next_field_index = field_in;
    wire next_receive_mode = s_rx;
    wire next_transmit_mode = ~s_rx;
    wire next_crc_check_enable = s_crc;
    wire next_packet_insert_enable = ~s_pass;
    wire next_tracker_enable = ~eff_fly_dis;
    wire next_sync_blank_enable = s_clip;
    wire next_clip_enable = s_clip;
    wire next_trs_insert_enable = s_clip;
    wire next_blanking_active = ~s_blank_n;
    // alternates every word, 0x200 first after reset
    wire next_word_phase = ~word_phase;
    // reversal after blanking, so blank levels are mirrored too
    wire [9:0] next_video_out = s_lsb ? reverse10(staged) : staged;

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            field_index <= `EDHCPD_FIELD_RST;
        end else begin
            field_index <= next_field_index;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            receive_mode <= `EDHCPD_FLAG_RST;
        end else begin
            receive_mode <= next_receive_mode;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            transmit_mode <= `EDHCPD_FLAG_RST;
        end else begin
            transmit_mode <= next_transmit_mode;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            crc_check_enable <= `EDHCPD_FLAG_RST;
        end else begin
            crc_check_enable <= next_crc_check_enable;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            vblank_lines <= `EDHCPD_VBI_NTSC_LONG;
        end else begin
            vblank_lines <= next_vblank_lines;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            packet_insert_enable <= `EDHCPD_FLAG_RST;
        end else begin
            packet_insert_enable <= next_packet_insert_enable;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tracker_enable <= `EDHCPD_FLAG_RST;
        end else begin
            tracker_enable <= next_tracker_enable;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_blank_enable <= `EDHCPD_FLAG_RST;
        end else begin
            sync_blank_enable <= next_sync_blank_enable;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            clip_enable <= `EDHCPD_FLAG_RST;
        end else begin
            clip_enable <= next_clip_enable;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            trs_insert_enable <= `EDHCPD_FLAG_RST;
        end else begin
            trs_insert_enable <= next_trs_insert_enable;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            blanking_active <= `EDHCPD_FLAG_RST;
        end else begin
            blanking_active <= next_blanking_active;
        end
    end

    // word parity for the blanking level
    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            word_phase <= `EDHCPD_FLAG_RST;
        end else begin
            word_phase <= next_word_phase;
        end
    end

    always @(posedge pixel_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            video_out <= `EDHCPD_VIDEO_RST;
        end else begin
            video_out <= next_video_out;
        end
    end
endmodule // edhcpd_decode

// ===== sim/edhcpd_properties.sv
// assertions on the control pin decoder ports
`timescale 1ns/10ps
module edhcpd_properties (
    input wire pixel_clock_in, input wire rst_n, input wire rx_tx_select,
    input wire crc_mode_pin, input wire error_packet_passthru, input wire blank_en_n,
    input wire timing_tracker_disable, input wire host_timing_tracker_disable,
    input wire clip_and_sync_fix_enable, input wire [2:0] field_in,
    input wire [2:0] field_index, input wire receive_mode, input wire transmit_mode,
    input wire crc_check_enable, input wire packet_insert_enable, input wire tracker_enable,
    input wire clip_enable, input wire trs_insert_enable, input wire blanking_active
);
    default clocking @(posedge pixel_clock_in); endclocking
    default disable iff (!rst_n);
    // pins take two sync flops plus the output flop, so look three edges back
    property p_rx; $past(rst_n, 3) |-> receive_mode == $past(rx_tx_select, 3); endproperty
    a_rx: assert property (p_rx) else $error("bad receive");
    property p_tx; $past(rst_n, 3) |-> transmit_mode != $past(rx_tx_select, 3); endproperty
    a_tx: assert property (p_tx) else $error("bad transmit");
    property p_crc; $past(rst_n, 3) |-> crc_check_enable == $past(crc_mode_pin, 3); endproperty
    a_crc: assert property (p_crc) else $error("bad crc");
    property p_pkt; $past(rst_n, 3) |-> packet_insert_enable != $past(error_packet_passthru, 3);
    endproperty
    a_pkt: assert property (p_pkt) else $error("bad passthru");
    property p_trk; $past(rst_n, 3) |-> tracker_enable !=
        ($past(timing_tracker_disable, 3) || $past(host_timing_tracker_disable)); endproperty
    a_trk: assert property (p_trk) else $error("bad tracker");
    property p_clip; $past(rst_n, 3) |->
        {clip_enable, trs_insert_enable} == {2{$past(clip_and_sync_fix_enable, 3)}}; endproperty
    a_clip: assert property (p_clip) else $error("bad clip");
    property p_blank; $past(rst_n, 3) |-> blanking_active != $past(blank_en_n, 3); endproperty
    a_blank: assert property (p_blank) else $error("bad blanking");
    property p_field; $past(rst_n) |-> field_index == $past(field_in); endproperty
    a_field: assert property (p_field) else $error("bad field");
endmodule // edhcpd_properties

// ===== sim/edhcpd_board.sv
// board logic that drives the static control pins
`timescale 1ns/10ps
module edhcpd_board (
    input wire clk,
    input wire [9:0] cfg,
    input wire pal_comp,
    output wire [9:0] pins
);
    reg [9:0] held = 10'h000;
    assign pins = held;
    always @(negedge clk) begin
        held <= pal_comp ? cfg & 10'h37F : cfg;
    end
endmodule // edhcpd_board

// ===== sim/tb_top.sv
// testbench for the control pin decoder
`timescale 1ns/10ps
module tb_top;
    reg pixel_clock_in = 1'b0;
    reg rst_n = 1'b0;
    reg is_pal = 1'b0;
    reg is_composite = 1'b0;
    reg [2:0] field_in = 3'h0;
    reg [9:0] video_in = 10'h003;
    reg [9:0] cfg = 10'h008;
    wire [9:0] p;
    wire rx_tx_select, crc_mode_pin, vblank_length_select, host_vblank_length_select,
        error_packet_passthru, lsb_top_pin, blank_en_n, timing_tracker_disable,
        clip_and_sync_fix_enable, host_timing_tracker_disable;
    wire [2:0] field_index;
    wire [4:0] vblank_lines;
    wire [9:0] video_out;
    wire receive_mode, transmit_mode, crc_check_enable, packet_insert_enable, tracker_enable,
        sync_blank_enable, clip_enable, trs_insert_enable, blanking_active;
    wire [9:0] flags = {receive_mode, transmit_mode, crc_check_enable, packet_insert_enable,
        tracker_enable, clip_enable, trs_insert_enable, sync_blank_enable, blanking_active, 1'b0};
    integer errors = 0;
    integer total_checks = 0;
    integer i;
    assign {rx_tx_select, crc_mode_pin, vblank_length_select, host_vblank_length_select,
        error_packet_passthru, lsb_top_pin, blank_en_n, timing_tracker_disable,
        clip_and_sync_fix_enable, host_timing_tracker_disable} = p;
    edhcpd_board u_board (.clk(pixel_clock_in), .cfg(cfg), .pal_comp(is_pal & ~is_composite),
        .pins(p));
    edhcpd_decode u_dut (
        .pixel_clock_in(pixel_clock_in),
        .rst_n(rst_n),
        .rx_tx_select(rx_tx_select),
        .crc_mode_pin(crc_mode_pin),
        .vblank_length_select(vblank_length_select),
        .host_vblank_length_select(host_vblank_length_select),
        .error_packet_passthru(error_packet_passthru),
        .lsb_top_pin(lsb_top_pin),
        .blank_en_n(blank_en_n),
        .timing_tracker_disable(timing_tracker_disable),
        .host_timing_tracker_disable(host_timing_tracker_disable),
        .clip_and_sync_fix_enable(clip_and_sync_fix_enable),
        .is_pal(is_pal),
        .is_composite(is_composite),
        .field_in(field_in),
        .video_in(video_in),
        .field_index(field_index),
        .receive_mode(receive_mode),
        .transmit_mode(transmit_mode),
        .crc_check_enable(crc_check_enable),
        .vblank_lines(vblank_lines),
        .packet_insert_enable(packet_insert_enable),
        .tracker_enable(tracker_enable),
        .sync_blank_enable(sync_blank_enable),
        .clip_enable(clip_enable),
        .trs_insert_enable(trs_insert_enable),
        .blanking_active(blanking_active),
        .video_out(video_out)
    );
    initial begin
        forever #5 pixel_clock_in = ~pixel_clock_in;
    end
    function [9:0] expf(input [9:0] c);
        expf = {c[9], !c[9], c[8], !c[5], !(c[2] | c[0]), c[1], c[1], c[1], !c[3], 1'b0};
    endfunction
    task chk(input [9:0] got, input [9:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // board change, then two sync flops and the output flop settle
    task setc(input [9:0] c);
        begin
            cfg = c;
            repeat (6) @(negedge pixel_clock_in);
        end
    endtask
    task tally_and_finish;
        begin
            $display("errors %0d checks %0d", errors, total_checks);
            if (errors == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(negedge pixel_clock_in);
        chk({vblank_lines, flags[9:5]}, {5'h13, 5'h00});
        rst_n = 1'b1;
        for (i = 0; i < 20; i = i + 1) begin
            field_in = i[2:0];
            setc(i < 10 ? 10'h001 << i : ~(10'h001 << (i - 10)));
            chk(flags, expf(cfg));
            chk({5'h00, vblank_lines}, (cfg[7] & cfg[6]) ? 10'h009 : 10'h013);
            chk({7'h00, field_index}, {7'h00, field_in});
            if (cfg[3]) chk(video_out, cfg[4] ? 10'h300 : 10'h003);
            else if (cfg[4]) chk({9'h000, video_out == 10'h001 || video_out == 10'h008},
                10'h001);
            else chk({9'h000, video_out == 10'h200 || video_out == 10'h040}, 10'h001);
        end
        is_pal = 1'b1;
        is_composite = 1'b1;
        setc(10'h0C8);
        chk({5'h00, vblank_lines}, 10'h007);
        setc(10'h008);
        chk({5'h00, vblank_lines}, 10'h011);
        is_composite = 1'b0;
        setc(10'h0C8);
        chk({5'h00, vblank_lines}, 10'h011);
        rst_n = 1'b0;
        @(negedge pixel_clock_in);
        chk({vblank_lines, flags[9:5]}, {5'h13, 5'h00});
        repeat (3) @(negedge pixel_clock_in);
        rst_n = 1'b1;
        setc(10'h300);
        chk(flags, expf(cfg));
        tally_and_finish;
    end
endmodule // tb_top
bind edhcpd_decode edhcpd_properties u_props (
    .pixel_clock_in(pixel_clock_in),
    .rst_n(rst_n),
    .rx_tx_select(rx_tx_select),
    .crc_mode_pin(crc_mode_pin),
    .error_packet_passthru(error_packet_passthru),
    .blank_en_n(blank_en_n),
    .timing_tracker_disable(timing_tracker_disable),
    .host_timing_tracker_disable(host_timing_tracker_disable),
    .clip_and_sync_fix_enable(clip_and_sync_fix_enable),
    .field_in(field_in),
    .field_index(field_index),
    .receive_mode(receive_mode),
    .transmit_mode(transmit_mode),
    .crc_check_enable(crc_check_enable),
    .packet_insert_enable(packet_insert_enable),
    .tracker_enable(tracker_enable),
    .clip_enable(clip_enable),
    .trs_insert_enable(trs_insert_enable),
    .blanking_active(blanking_active)
);
